// File: logic/wdt_supervisor.sv
// watchdog timer, software-reset keys and low-voltage reset qualifier
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module wdt_supervisor
   import wdt_supervisor_pkg::*;
#(
   parameter int LVR_QUALIFY_TIME_US = LVR_QUALIFY_US, // qualify time, us
   parameter int SRESET_DELAY_SUB    = SRESET_SUB_CYC  // delay, sub cycles
)(
   input  wire logic              clk,                  // 20 MHz clock
   input  wire logic              rst_n,                // power-on reset
   input  wire logic [ADDR_W-1:0] addr,                 // register index
   input  wire logic [DATA_W-1:0] wdata,                // write data
   input  wire logic              wr,                   // write strobe
   input  wire logic              rd,                   // read strobe
   output logic [DATA_W-1:0]      rdata,                // read data
   input  wire logic              sub_clock,            // sub clock pin
   input  wire logic              low_supply,           // supply low pin
   input  wire logic              clear_wdt_insn,       // clear instruction
   input  wire logic              halt_insn,            // halt instruction
   input  wire logic              sleep_idle,           // in sleep or idle
   input  wire logic              power_down,           // in power down
   output logic                   device_reset,         // full reset pulse
   output logic                   pc_sp_clear,          // pc and sp clear
   output logic                   timeout_status_flag,  // time-out flag
   output logic                   system_clock_in_idle, // fsys in idle
   output logic [DATA_W-1:0]      threshold_code,       // threshold select
   output logic                   por_init,             // pc and port init
   output logic [DATA_W-1:0]      port_init_value       // port init value
);
   localparam int LVR_CYC_RAW = LVR_QUALIFY_TIME_US * CLK_FREQ_MHZ;
   localparam int LVR_CYC     = (LVR_CYC_RAW < 1) ? 1 : LVR_CYC_RAW;
   localparam int LVR_W       = $clog2(LVR_CYC + 1);
   localparam int SRST_W      = $clog2(SRESET_DELAY_SUB + 1);
   localparam logic [LVR_W-1:0]  LVR_LIMIT  = LVR_W'(LVR_CYC);
   localparam logic [SRST_W-1:0] SRST_LIMIT = SRST_W'(SRESET_DELAY_SUB);

   typedef enum logic [1:0] {ST_IDLE, ST_SRST_WAIT, ST_SRST_FIRE} srst_e;

   logic [2:0]           sub_sync_reg;
   logic [1:0]           low_sync_reg;
   logic                 sub_tick;
   logic                 low_s;
   logic [DATA_W-1:0]    wdt_ctrl_reg;
   logic [DATA_W-1:0]    sys_flags_reg;
   logic [DATA_W-1:0]    lv_thresh_reg;
   logic [WDT_CNT_W-1:0] wdt_cnt_reg;
   logic [LVR_W-1:0]     lvr_cnt_reg;
   logic                 lvr_fired_reg;
   logic [SRST_W-1:0]    srst_cnt_reg;
   srst_e                srst_reg;
   srst_e                srst_next;
   logic [DATA_W-1:0]    rdata_reg;
   logic                 device_reset_reg;
   logic                 pc_sp_clear_reg;
   logic                 timeout_reg;
   logic                 por_init_reg;
   logic [DATA_W-1:0]    port_init_reg;
   logic [4:0]           key;
   logic                 key_bad;
   logic                 thr_bad;
   logic                 wdt_run;
   logic                 wdt_ovf;
   logic                 ovf_normal;
   logic                 ovf_sleep;
   logic                 lvr_fire;
   logic                 srst_start;
   logic                 srst_fire;
   logic                 full_rst;

   // sub clock and supply pin synchronisers; edge taken after stage two
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sub_sync_reg <= 3'h0;
         low_sync_reg <= 2'h0;
      end
      else
      begin
         sub_sync_reg <= {sub_sync_reg[1:0], sub_clock};
         low_sync_reg <= {low_sync_reg[0], low_supply};
      end
   end

   assign sub_tick = sub_sync_reg[1] && !sub_sync_reg[2];
   assign low_s    = low_sync_reg[1];

   assign key        = wdt_ctrl_reg[KEY_MSB:KEY_LSB];
   assign key_bad    = (key != KEY_DISABLE) && (key != KEY_ENABLE);
   assign thr_bad    = !thresh_valid(lv_thresh_reg);
   assign wdt_run    = (key == KEY_ENABLE) && (srst_reg == ST_IDLE);
   assign wdt_ovf    = wdt_run && sub_tick && (wdt_cnt_reg ==
                       period_limit(wdt_ctrl_reg[PSEL_MSB:PSEL_LSB]));
   assign ovf_normal = wdt_ovf && !sleep_idle;
   assign ovf_sleep  = wdt_ovf && sleep_idle;
   // a bad key or threshold is caught whenever it appears, not only on write
   assign srst_start = (srst_reg == ST_IDLE) && (key_bad || thr_bad);
   assign srst_fire  = (srst_reg == ST_SRST_FIRE);
   assign lvr_fire   = low_s && !power_down && !lvr_fired_reg &&
                       (lvr_cnt_reg == LVR_LIMIT);
   assign full_rst   = ovf_normal || lvr_fire || srst_fire;

   // software reset sequencer: wait the delay in sub ticks, then fire
   always_comb
   begin
      srst_next = srst_reg;
      case (srst_reg)
         ST_IDLE:
            if (key_bad || thr_bad)
               srst_next = ST_SRST_WAIT;
         ST_SRST_WAIT:
            if (sub_tick && (srst_cnt_reg >= SRST_LIMIT))
               srst_next = ST_SRST_FIRE;
         ST_SRST_FIRE:
            srst_next = ST_IDLE;
         default:
            srst_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         srst_reg <= ST_IDLE;
      else
         srst_reg <= srst_next;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         srst_cnt_reg <= '0;
      else if (srst_reg != ST_SRST_WAIT)
         srst_cnt_reg <= '0;
      else if (sub_tick && (srst_cnt_reg < SRST_LIMIT))
         srst_cnt_reg <= srst_cnt_reg + SRST_W'(1);
   end

   // watchdog counter
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         wdt_cnt_reg <= '0;
      else if (!wdt_run || clear_wdt_insn || halt_insn || full_rst ||
               wdt_ovf)
         wdt_cnt_reg <= '0;
      else if (sub_tick)
         wdt_cnt_reg <= wdt_cnt_reg + WDT_CNT_W'(1);
   end

   // watchdog control register; every full reset reloads it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         wdt_ctrl_reg <= WDT_CTRL_POR;
      else if (full_rst)
         wdt_ctrl_reg <= WDT_CTRL_POR;
      else if (wr && (addr == OFS_WDT_CTRL))
         wdt_ctrl_reg <= wdata;
   end

   // threshold register; only an invalid code reloads it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         lv_thresh_reg <= LV_THRESH_POR;
      else if (srst_fire && thr_bad)
         lv_thresh_reg <= LV_THRESH_POR;
      else if (wr && (addr == OFS_LV_THRESH) && !lvr_fire)
         lv_thresh_reg <= wdata;
   end

   // reset-cause flags: hardware set wins over a software write
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         sys_flags_reg <= SYS_FLAGS_POR;
      else
      begin
         if (wr && (addr == OFS_SYS_FLAGS))
            sys_flags_reg <= wdata & SYS_FLAGS_MASK;
         if (srst_start && key_bad)
            sys_flags_reg[BIT_WRF] <= 1'b1;
         if (srst_start && thr_bad)
            sys_flags_reg[BIT_LRF] <= 1'b1;
         if (lvr_fire)
            sys_flags_reg[BIT_LOW_VOLTAGE_RESET_FLAG] <= 1'b1;
      end
   end

   // low-voltage qualify counter, rearmed when the supply recovers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lvr_cnt_reg   <= '0;
         lvr_fired_reg <= 1'b0;
      end
      else if (!low_s || power_down)
      begin
         lvr_cnt_reg   <= '0;
         lvr_fired_reg <= 1'b0;
      end
      else
      begin
         if (lvr_cnt_reg < LVR_LIMIT)
            lvr_cnt_reg <= lvr_cnt_reg + LVR_W'(1);
         if (lvr_fire)
            lvr_fired_reg <= 1'b1;
      end
   end

   // time-out flag: set by overflow, cleared by halt; set wins
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         timeout_reg <= 1'b0;
      else if (wdt_ovf)
         timeout_reg <= 1'b1;
      else if (halt_insn)
         timeout_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         device_reset_reg <= 1'b0;
         pc_sp_clear_reg  <= 1'b0;
      end
      else
      begin
         device_reset_reg <= full_rst;
         pc_sp_clear_reg  <= ovf_sleep || full_rst;
      end
   end

   // program counter and port preset on power-on and full resets
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         por_init_reg  <= 1'b1;
         port_init_reg <= PORT_POR_VALUE;
      end
      else
      begin
         por_init_reg  <= full_rst;
         port_init_reg <= PORT_POR_VALUE;
      end
   end

   // register read, data valid in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata_reg <= '0;
      else if (rd)
      begin
         case (addr)
            OFS_WDT_CTRL:  rdata_reg <= wdt_ctrl_reg;
            OFS_SYS_FLAGS: rdata_reg <= sys_flags_reg & SYS_FLAGS_MASK;
            OFS_LV_THRESH: rdata_reg <= lv_thresh_reg;
            default:       rdata_reg <= '0;
         endcase
      end
      else
         rdata_reg <= '0;
   end

   assign rdata                = rdata_reg;
   assign device_reset         = device_reset_reg;
   assign pc_sp_clear          = pc_sp_clear_reg;
   assign timeout_status_flag  = timeout_reg;
   assign system_clock_in_idle = sys_flags_reg[BIT_FSYS];
   assign threshold_code       = lv_thresh_reg;
   assign por_init             = por_init_reg;
   assign port_init_value      = port_init_reg;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_ovf_normal;
      wdt_ovf && !sleep_idle;
   endsequence

   sequence s_ovf_sleep;
      wdt_ovf && sleep_idle;
   endsequence

   sequence s_bad_key_seen;
      (srst_reg == ST_IDLE) && key_bad;
   endsequence

   AST_TO_RESET: assert property (
      s_ovf_normal |=> device_reset && timeout_status_flag)
      else $error("normal overflow did not reset");
   AST_SLEEP_PCSP: assert property (
      s_ovf_sleep ##0 !full_rst |=> pc_sp_clear && !device_reset &&
      timeout_status_flag)
      else $error("sleep overflow did a full reset");
   AST_KEY_WRF: assert property (
      s_bad_key_seen |=> sys_flags_reg[BIT_WRF] &&
      (srst_reg == ST_SRST_WAIT))
      else $error("bad key not flagged");
   AST_WRF_HOLD: assert property (
      sys_flags_reg[BIT_WRF] && !(wr && (addr == OFS_SYS_FLAGS))
      |=> sys_flags_reg[BIT_WRF])
      else $error("wrf dropped without a write");
   AST_CLR: assert property (
      clear_wdt_insn || halt_insn |=> wdt_cnt_reg == '0)
      else $error("counter not cleared");
   AST_DISABLED: assert property (
      key == KEY_DISABLE |=> wdt_cnt_reg == '0 && !$rose(timeout_reg))
      else $error("disabled watchdog counting");
   AST_LVR_QUAL: assert property (
      lvr_fire |=> device_reset && sys_flags_reg[BIT_LOW_VOLTAGE_RESET_FLAG])
      else $error("qualified low supply did not reset");
   AST_LVR_SHORT: assert property (
      !low_s |=> lvr_cnt_reg == '0 ##1 !lvr_fire)
      else $error("short low supply not ignored");
   AST_PD: assert property (
      power_down |-> !lvr_fire)
      else $error("low-voltage reset in power down");
   AST_LOW_VOLTAGE_THRESHOLD_SELECT_KEEP: assert property (
      lvr_fire && !srst_fire |=> $stable(lv_thresh_reg))
      else $error("threshold changed by low-voltage reset");
   AST_LOW_VOLTAGE_THRESHOLD_SELECT_BAD: assert property (
      srst_fire && thr_bad |=> lv_thresh_reg == LV_THRESH_POR &&
      sys_flags_reg[BIT_LRF] && device_reset)
      else $error("bad threshold not reloaded");
   AST_RSV: assert property (
      rd && (addr == OFS_SYS_FLAGS) |=> rdata[6:4] == 3'h0)
      else $error("reserved bits read nonzero");
   AST_RST_PULSE: assert property (
      s_ovf_normal |=> wdt_ctrl_reg == WDT_CTRL_POR && pc_sp_clear &&
      por_init)
      else $error("time-out reset not handled as a full reset");

   // flags and sequencing that software relies on after a reset
   AST_LOW_VOLTAGE_RESET_FLAG_HOLD: assert property (
      sys_flags_reg[BIT_LOW_VOLTAGE_RESET_FLAG] && !(wr && (addr == OFS_SYS_FLAGS))
      |=> sys_flags_reg[BIT_LOW_VOLTAGE_RESET_FLAG])
      else $error("low_voltage_reset_flag dropped without a write");

   AST_LRF_HOLD: assert property (
      sys_flags_reg[BIT_LRF] && !(wr && (addr == OFS_SYS_FLAGS))
      |=> sys_flags_reg[BIT_LRF])
      else $error("lrf dropped without a write");

   AST_LRF_SET: assert property (
      (srst_reg == ST_IDLE) && thr_bad |=> sys_flags_reg[BIT_LRF])
      else $error("bad threshold not flagged");

   AST_TO_HOLD: assert property (
      timeout_status_flag && !halt_insn |=> timeout_status_flag)
      else $error("time-out flag dropped without halt");

   AST_POR_PRESET: assert property (
      full_rst |=> por_init && (port_init_value == PORT_POR_VALUE))
      else $error("full reset did not preset pc and ports");

   AST_SRST_TICK: assert property (
      (srst_reg == ST_SRST_WAIT) && !sub_tick |=>
      srst_reg == ST_SRST_WAIT)
      else $error("software reset delay not counted in sub ticks");

   AST_MAX_PERIOD: assert property (
      wdt_ovf && (wdt_ctrl_reg[PSEL_MSB:PSEL_LSB] == 3'h7) |->
      wdt_cnt_reg == '1)
      else $error("longest period is not the full counter");

   AST_SRST_FULL: assert property (
      srst_fire |=> device_reset && pc_sp_clear &&
      wdt_ctrl_reg == WDT_CTRL_POR)
      else $error("software reset not handled as a full reset");
endmodule

// File: logic/wdt_supervisor_pkg.sv
// constants for the watchdog and reset-source supervisor
package wdt_supervisor_pkg;
   localparam int           ADDR_W          = 2;
   localparam int           DATA_W          = 8;
   localparam int           WDT_CNT_W       = 18;
   localparam logic [1:0]   OFS_WDT_CTRL    = 2'h0;
   localparam logic [1:0]   OFS_SYS_FLAGS   = 2'h1;
   localparam logic [1:0]   OFS_LV_THRESH   = 2'h2;
   // watchdog control fields
   localparam int           KEY_MSB         = 7;
   localparam int           KEY_LSB         = 3;
   localparam int           PSEL_MSB        = 2;
   localparam int           PSEL_LSB        = 0;
   localparam logic [4:0]   KEY_DISABLE     = 5'h15;
   localparam logic [4:0]   KEY_ENABLE      = 5'h0a;
   localparam logic [7:0]   WDT_CTRL_POR    = 8'h53;
   // control and flag register fields
   localparam int           BIT_WRF         = 0;
   localparam int           BIT_LRF         = 1;
   localparam int           BIT_LOW_VOLTAGE_RESET_FLAG        = 2;
   localparam int           BIT_SUBF        = 3;
   localparam int           BIT_FSYS        = 7;
   localparam logic [7:0]   SYS_FLAGS_MASK  = 8'h8f;
   localparam logic [7:0]   SYS_FLAGS_POR   = 8'h00;
   // threshold codes
   localparam logic [7:0]   THR_2V10        = 8'h55;
   localparam logic [7:0]   THR_2V55        = 8'h33;
   localparam logic [7:0]   THR_3V15        = 8'h99;
   localparam logic [7:0]   THR_3V80        = 8'haa;
   localparam logic [7:0]   LV_THRESH_POR   = 8'h55;
   localparam logic [7:0]   PORT_POR_VALUE  = 8'hff;
   // time-out exponent per period select code
   localparam logic [4:0]   PERIOD_EXP [8]  = '{5'h08, 5'h0a, 5'h0c, 5'h0e,
                                                5'h0f, 5'h10, 5'h11, 5'h12};
   // timing
   localparam int           CLK_FREQ_MHZ    = 20;
   localparam int           LVR_QUALIFY_US  = 100;
   localparam int           SRESET_SUB_CYC  = 4;

   function automatic logic [WDT_CNT_W-1:0] period_limit(
      input logic [2:0] psel);
      logic [WDT_CNT_W:0] one;
      one = (WDT_CNT_W+1)'(1);
      period_limit = WDT_CNT_W'((one << PERIOD_EXP[psel]) - one);
   endfunction

   function automatic logic thresh_valid(input logic [7:0] code);
      thresh_valid = (code == THR_2V10) || (code == THR_2V55) ||
                     (code == THR_3V15) || (code == THR_3V80);
   endfunction
endpackage

// File: tb/wdt_supervisor_tb.sv
// self-checking bench for the watchdog and reset-source supervisor
`timescale 1ns/10ps
module wdt_supervisor_tb;
   import wdt_supervisor_pkg::*;
   logic       clk = 1'h0;
   logic       rst_n = 1'h0;
   logic       wr = 1'h0;
   logic       rd = 1'h0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic       sub_clock = 1'h0;
   logic       low_supply = 1'h0;
   logic       clr = 1'h0;
   logic       halt = 1'h0;
   logic       sleep = 1'h0;
   logic       pdown = 1'h0;
   logic [7:0] rdata, thr, port_v;
   logic       dev_rst, pcsp, to_flag, fsys, por, dr, ps;
   int         fail_count = 0;
   int         compares = 0;
   int         ticks = 0;
   int         sub_div = 0;
   int         n;

   wdt_supervisor #(.LVR_QUALIFY_TIME_US(1), .SRESET_DELAY_SUB(1))
   i_wdt_supervisor (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .sub_clock(sub_clock),
      .low_supply(low_supply), .clear_wdt_insn(clr), .halt_insn(halt),
      .sleep_idle(sleep), .power_down(pdown), .device_reset(dev_rst),
      .pc_sp_clear(pcsp), .timeout_status_flag(to_flag),
      .system_clock_in_idle(fsys), .threshold_code(thr), .por_init(por),
      .port_init_value(port_v));

   initial
   begin
      forever #25 clk = ~clk;
   end

   // slow sub clock, one rising edge every 16 clk cycles
   always @(posedge clk)
   begin
      sub_div <= (sub_div == 7) ? 0 : sub_div + 1;
      if (sub_div == 7)
      begin
         sub_clock <= ~sub_clock;
         if (!sub_clock)
            ticks <= ticks + 1;
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, g);
      compares++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask

   task automatic rchk(input string nm, input logic [1:0] a,
                       input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 chk(nm, e, rdata);
   endtask

   // waits for a full reset or a pc/sp clear pulse
   task automatic wait_rst(input int lim);
      dr = 1'h0;
      ps = 1'h0;
      for (int i = 0; i < lim && !(dr || ps); i++)
      begin
         @(posedge clk);
         #1;
         dr = dev_rst;
         ps = pcsp;
      end
   endtask

   // clear well away from a sub-clock edge so the tick count is exact
   task automatic clear_sync(output int t0);
      do
         @(posedge clk);
      while (!(sub_clock === 1'h0 && sub_div == 3));
      clr <= 1'h1;
      @(posedge clk);
      clr <= 1'h0;
      t0 = ticks;
   endtask

   task automatic t_flags;
      wr_reg(OFS_SYS_FLAGS, 8'hff);
      rchk("flags", OFS_SYS_FLAGS, SYS_FLAGS_MASK);
      chk("fsys_idle", 8'h01, 8'(fsys));
      wr_reg(OFS_SYS_FLAGS, 8'h00);
      rchk("flags", OFS_SYS_FLAGS, 8'h00);
   endtask

   task automatic t_thresh;
      logic [7:0] codes [4] = '{THR_2V10, THR_2V55, THR_3V15, THR_3V80};
      foreach (codes[i])
      begin
         wr_reg(OFS_LV_THRESH, codes[i]);
         wait_rst(100);
         chk("valid_code_reset", 8'h00, 8'(dr));
         chk("threshold_code", codes[i], thr);
      end
   endtask

   task automatic t_disable;
      wr_reg(OFS_WDT_CTRL, {KEY_DISABLE, 3'h0});
      wait_rst(5000);
      chk("disabled_reset", 8'h00, 8'(dr));
   endtask

   task automatic t_badkey;
      wr_reg(OFS_WDT_CTRL, 8'h00);
      wait_rst(100);
      chk("key_reset", 8'h01, 8'(dr));
      rchk("flags", OFS_SYS_FLAGS, 8'h01);
      rchk("watchdog_control", OFS_WDT_CTRL, WDT_CTRL_POR);
      wr_reg(OFS_SYS_FLAGS, 8'h00);
   endtask

   task automatic t_badthr;
      wr_reg(OFS_LV_THRESH, 8'h12);
      wait_rst(100);
      chk("thr_reset", 8'h01, 8'(dr));
      chk("threshold_code", LV_THRESH_POR, thr);
      rchk("flags", OFS_SYS_FLAGS, 8'h02);
      wr_reg(OFS_SYS_FLAGS, 8'h00);
   endtask

   task automatic t_lvr;
      wr_reg(OFS_LV_THRESH, THR_3V15);
      @(posedge clk);
      low_supply <= 1'h1;
      repeat (10) @(posedge clk);
      low_supply <= 1'h0;
      wait_rst(60);
      chk("short_low", 8'h00, 8'(dr));
      @(posedge clk);
      pdown <= 1'h1;
      low_supply <= 1'h1;
      wait_rst(60);
      chk("powered_down", 8'h00, 8'(dr));
      @(posedge clk);
      pdown <= 1'h0;
      wait_rst(40);
      chk("lvr_reset", 8'h01, 8'(dr));
      chk("threshold_code", THR_3V15, thr);
      @(posedge clk);
      low_supply <= 1'h0;
      rchk("flags", OFS_SYS_FLAGS, 8'h04);
      wr_reg(OFS_SYS_FLAGS, 8'h00);
   endtask

   task automatic t_timeout(input logic [2:0] code, input logic slp,
                            input int e);
      int t0;
      @(posedge clk);
      sleep <= slp;
      wr_reg(OFS_WDT_CTRL, {KEY_ENABLE, code});
      clear_sync(t0);
      while (ticks - t0 < (1 << e) - 8)
         @(posedge clk);
      clear_sync(t0);
      wait_rst((1 << e) * 16 + 40);
      n = ticks - t0;
      chk("ticks_match", 8'h01, 8'(n == (1 << e)));
      chk("timeout_reset", 8'(!slp), 8'(dr));
      chk("pc_sp_clear", 8'h01, 8'(ps));
      repeat (2) @(posedge clk);
      #1 chk("timeout_flag", 8'h01, 8'(to_flag));
      rchk("watchdog_control", OFS_WDT_CTRL,
           slp ? {KEY_ENABLE, code} : WDT_CTRL_POR);
      @(posedge clk);
      halt <= 1'h1;
      @(posedge clk);
      halt <= 1'h0;
      sleep <= 1'h0;
      repeat (2) @(posedge clk);
      #1 chk("timeout_flag", 8'h00, 8'(to_flag));
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      // the scenarios need about 45000 cycles, mostly the two time-outs
      repeat (60000) @(posedge clk);
      fail_count++;
      results;
   end

   initial
   begin
      @(posedge clk);
      #1 chk("por_init", 8'h01, 8'(por));
      chk("port_init", PORT_POR_VALUE, port_v);
      chk("threshold_code", LV_THRESH_POR, thr);
      @(posedge clk);
      rst_n <= 1'h1;
      rchk("watchdog_control", OFS_WDT_CTRL, WDT_CTRL_POR);
      rchk("flags", OFS_SYS_FLAGS, SYS_FLAGS_POR);
      rchk("threshold_sel", OFS_LV_THRESH, LV_THRESH_POR);
      rchk("unmapped", 2'h3, 8'h00);
      t_flags;
      t_thresh;
      t_disable;
      t_badkey;
      t_badthr;
      t_lvr;
      t_timeout(3'h0, 1'h0, 8);
      t_timeout(3'h1, 1'h1, 10);
      results;
   end
endmodule
